// file: common/rsse_pkg.sv
package rsse_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FILE_AW = 7;

  // byte offsets
  localparam logic [ADDR_W-1:0] OFF_CMD    = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_ACC    = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_WDOG   = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_FILE   = 12'h200;
  localparam int unsigned FILE_SEL_LSB = 9;
  localparam int unsigned WORD_LSB     = 2;

  // command register fields
  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_OP_W     = 3;
  localparam int unsigned CMD_DEST_BIT = 3;
  localparam int unsigned CMD_FA_LSB   = 4;
  localparam int unsigned CMD_LIT_LSB  = 16;
  localparam int unsigned CMD_USED_W   = 24;

  // status register bits
  localparam int unsigned ST_CARRY  = 0;
  localparam int unsigned ST_NIBBLE = 1;
  localparam int unsigned ST_ZERO   = 2;
  localparam int unsigned ST_DOZE   = 3;
  localparam int unsigned ST_EXPIRY = 4;
  localparam int unsigned ST_W      = 5;
  localparam logic [ST_W-1:0] ST_RESET = 5'h18;

  localparam int unsigned NIB_W = 4;
  localparam int unsigned PRE_W = 8;
  localparam logic [PRE_W-1:0] PRE_RESET  = 8'h00;
  localparam logic [BYTE_W-1:0] WDOG_RESET = 8'h00;

  typedef enum logic [CMD_OP_W-1:0] {
    RSSE_NOP,
    RSSE_ROTATE_RIGHT_CARRY,
    RSSE_ROTATE_LEFT_CARRY,
    RSSE_LITERAL_MINUS_ACC,
    RSSE_REG_MINUS_ACC,
    RSSE_REG_MINUS_ACC_BORROW,
    RSSE_SLEEP
  } rsse_op_e;
endpackage

// file: logic/rsse_alu.sv
`timescale 1ns/1ns
module rsse_alu (
  input  wire logic [rsse_pkg::CMD_OP_W-1:0] op,
  input  wire logic [rsse_pkg::BYTE_W-1:0]   operand,
  input  wire logic [rsse_pkg::BYTE_W-1:0]   acc,
  input  wire logic [rsse_pkg::BYTE_W-1:0]   literal,
  input  wire logic                          carry_in,
  output logic      [rsse_pkg::BYTE_W-1:0]   result,
  output logic                               carry_out,
  output logic                               nibble_out,
  output logic                               zero_out
);
  import rsse_pkg::*;

  logic [BYTE_W-1:0] minuend;
  logic              cin;
  logic [BYTE_W:0]   diff;
  logic [NIB_W:0]    ndiff;

  always_comb begin
    minuend = operand;
    cin     = 1'b1;
    if (op == RSSE_LITERAL_MINUS_ACC) begin
      minuend = literal;
    end
    if (op == RSSE_REG_MINUS_ACC_BORROW) begin
      cin = carry_in;
    end
  end

  // two's complement: a + ~w + cin, carry out means no borrow
  assign diff  = {1'b0, minuend} + {1'b0, ~acc} + {{BYTE_W{1'b0}}, cin};
  assign ndiff = {1'b0, minuend[NIB_W-1:0]} + {1'b0, ~acc[NIB_W-1:0]}
               + {{NIB_W{1'b0}}, cin};

  always_comb begin
    result     = diff[BYTE_W-1:0];
    carry_out  = diff[BYTE_W];
    nibble_out = ndiff[NIB_W];
    zero_out   = (diff[BYTE_W-1:0] == 8'h00);
    if (op == RSSE_ROTATE_RIGHT_CARRY) begin
      result    = {carry_in, operand[BYTE_W-1:1]};
      carry_out = operand[0];
    end else if (op == RSSE_ROTATE_LEFT_CARRY) begin
      result    = {operand[BYTE_W-2:0], carry_in};
      carry_out = operand[BYTE_W-1];
    end
  end
endmodule

// file: logic/rsse_core.sv
// Operation
// - rotate right through carry, only carry changes
// - dest 0 writes acc, 1 writes register
// - literal minus acc into acc, flags updated
// - literal subtract carry and nibble as no-borrow
// - register minus acc to selected destination
// - register subtract carry and nibble as no-borrow
// - register minus acc minus inverted carry
// - sleep clears watchdog counter and prescaler
// - sleep clears doze, sets expiry, nothing else
// - rotate left through carry, only carry changes
`timescale 1ns/1ns
module rsse_core (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [rsse_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [rsse_pkg::DATA_W-1:0]   pwdata,
  output logic      [rsse_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr
);
  import rsse_pkg::*;

  logic [BYTE_W-1:0]     file_mem [2**FILE_AW];
  logic [BYTE_W-1:0]     acc;
  logic [ST_W-1:0]       status;
  logic [CMD_USED_W-1:0] cmd;
  logic [BYTE_W-1:0]     watchdog_counter;
  logic [PRE_W-1:0]      prescaler;

  logic                  access;
  logic                  wr_en;
  logic                  exec;
  rsse_op_e              op;
  logic                  dest_reg;
  logic [FILE_AW-1:0]    fa;
  logic [BYTE_W-1:0]     literal;
  logic [BYTE_W-1:0]     alu_res;
  logic                  alu_c;
  logic                  alu_dc;
  logic                  alu_z;
  logic                  is_sub;
  logic                  is_rot;
  logic                  to_file;
  logic                  wdog_wrap;
  logic [DATA_W-1:0]     next_prdata;
  logic                  next_err;

  function automatic logic is_file(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:FILE_SEL_LSB] == OFF_FILE[ADDR_W-1:FILE_SEL_LSB];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return is_file(a) || a == OFF_CMD || a == OFF_ACC
        || a == OFF_STATUS || a == OFF_WDOG;
  endfunction

  // access phase ends one cycle after penable rises
  assign access = psel && penable && !pready;
  assign wr_en  = psel && penable && pready && pwrite;
  assign exec   = wr_en && paddr == OFF_CMD;

  assign op       = rsse_op_e'(pwdata[CMD_OP_LSB +: CMD_OP_W]);
  assign dest_reg = pwdata[CMD_DEST_BIT];
  assign fa       = pwdata[CMD_FA_LSB +: FILE_AW];
  assign literal  = pwdata[CMD_LIT_LSB +: BYTE_W];

  assign is_sub = op == RSSE_LITERAL_MINUS_ACC || op == RSSE_REG_MINUS_ACC
               || op == RSSE_REG_MINUS_ACC_BORROW;
  assign is_rot = op == RSSE_ROTATE_RIGHT_CARRY
               || op == RSSE_ROTATE_LEFT_CARRY;
  // literal form always lands in the accumulator
  assign to_file = exec && (is_sub || is_rot) && dest_reg
                && op != RSSE_LITERAL_MINUS_ACC;

  rsse_alu rsse_alu_i (
    .op         (op),
    .operand    (file_mem[fa]),
    .acc        (acc),
    .literal    (literal),
    .carry_in   (status[ST_CARRY]),
    .result     (alu_res),
    .carry_out  (alu_c),
    .nibble_out (alu_dc),
    .zero_out   (alu_z)
  );

  // file registers; an array has no reset
  always_ff @(posedge pclk) begin
    if (to_file) begin
      file_mem[fa] <= alu_res;
    end else if (wr_en && is_file(paddr)) begin
      file_mem[paddr[WORD_LSB +: FILE_AW]] <= pwdata[BYTE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= '0;
    end else if (exec && (is_sub || is_rot) && !to_file) begin
      acc <= alu_res;
    end else if (wr_en && paddr == OFF_ACC) begin
      acc <= pwdata[BYTE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= '0;
    end else if (exec) begin
      cmd <= pwdata[CMD_USED_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= ST_RESET;
    end else begin
      if (exec && is_rot) begin
        status[ST_CARRY] <= alu_c;
      end else if (exec && is_sub) begin
        status[ST_CARRY]  <= alu_c;
        status[ST_NIBBLE] <= alu_dc;
        status[ST_ZERO]   <= alu_z;
      end else if (exec && op == RSSE_SLEEP) begin
        status[ST_DOZE]   <= 1'b0;
        status[ST_EXPIRY] <= 1'b1;
      end else if (wr_en && paddr == OFF_STATUS) begin
        status <= pwdata[ST_W-1:0];
      end
      // a watchdog wrap clears expiry, over a status write too, unless a sleep command comes in the same cycle
      if (wdog_wrap && !(exec && op == RSSE_SLEEP)) begin
        status[ST_EXPIRY] <= 1'b0;
      end
    end
  end

  // free-running watchdog: prescaler wraps advance the counter
  assign wdog_wrap = &prescaler && &watchdog_counter;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler        <= PRE_RESET;
      watchdog_counter <= WDOG_RESET;
    end else if (exec && op == RSSE_SLEEP) begin
      prescaler        <= PRE_RESET;
      watchdog_counter <= WDOG_RESET;
    end else begin
      prescaler <= prescaler + 8'h01;
      if (&prescaler) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
    end
  end

  always_comb begin
    next_prdata = '0;
    next_err    = !mapped(paddr);
    if (is_file(paddr)) begin
      next_prdata[BYTE_W-1:0] = file_mem[paddr[WORD_LSB +: FILE_AW]];
    end else if (paddr == OFF_CMD) begin
      next_prdata[CMD_USED_W-1:0] = cmd;
    end else if (paddr == OFF_ACC) begin
      next_prdata[BYTE_W-1:0] = acc;
    end else if (paddr == OFF_STATUS) begin
      next_prdata[ST_W-1:0] = status;
    end else if (paddr == OFF_WDOG) begin
      next_prdata[BYTE_W-1:0]      = watchdog_counter;
      next_prdata[BYTE_W +: PRE_W] = prescaler;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= access;
      pslverr <= access && next_err;
      if (access && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end
endmodule

// file: tb/rsse_core_sva.sv
`timescale 1ns/1ns
module rsse_core_sva (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [rsse_pkg::ADDR_W-1:0] paddr,
  input wire logic [rsse_pkg::DATA_W-1:0] pwdata,
  input wire logic [rsse_pkg::DATA_W-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr
);
  import rsse_pkg::*;
  logic [CMD_OP_W-1:0] last_op;
  logic                fresh;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // op field of the last write, and whether that write went to the command register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_op <= '0;
      fresh <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      last_op <= pwdata[CMD_OP_W-1:0];
      fresh <= paddr == OFF_CMD;
    end
  end
  property p_answer; psel && !penable |-> ##2 pready; endproperty
  a_answer: assert property (p_answer) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_unmap;
    pready && paddr[11:10] != 2'b00 |-> pslverr && (pwrite || prdata == 0);
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_map;
    pready && paddr[11:4] == 0 && paddr[1:0] == 0 |-> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  property p_hold;
    !(psel && penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("prdata moved");
  property p_sleep_st;
    pready && !pwrite && paddr == OFF_STATUS && fresh &&
      last_op == RSSE_SLEEP |-> !prdata[ST_DOZE] && prdata[ST_EXPIRY];
  endproperty
  a_sleep_st: assert property (p_sleep_st) else $error("sleep status");
  property p_sleep_wd;
    pready && !pwrite && paddr == OFF_WDOG && fresh &&
      last_op == RSSE_SLEEP |-> prdata[7:0] == 0;
  endproperty
  a_sleep_wd: assert property (p_sleep_wd) else $error("sleep watchdog");
endmodule
bind rsse_core rsse_core_sva rsse_core_sva_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

// file: tb/test_rsse_core.sv
`timescale 1ns/1ns
module test_rsse_core;
  import rsse_pkg::*;
  typedef struct packed {
    logic [2:0] op;
    logic       d;
    logic [7:0] k, w, f;
    logic [2:0] s;
    logic [7:0] r;
    logic [2:0] fl;
  } rsse_row_s;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [DATA_W-1:0] rd;
  logic              err;
  logic [ADDR_W-1:0] fa;
  logic              to_acc;
  rsse_row_s         rw;
  int                mismatches = 0;
  int                tests_run = 0;
  // op, dest, literal, acc, file, flags in, result, flags out {z,n,c}
  rsse_row_s rows [13] = '{
    '{3'h1, 1'h1, 8'h00, 8'h11, 8'he7, 3'h6, 8'h73, 3'h7},
    '{3'h1, 1'h0, 8'h00, 8'h22, 8'h02, 3'h1, 8'h81, 3'h0},
    '{3'h2, 1'h0, 8'h00, 8'h33, 8'he6, 3'h0, 8'hcc, 3'h1},
    '{3'h2, 1'h1, 8'h00, 8'h44, 8'h01, 3'h7, 8'h03, 3'h6},
    '{3'h3, 1'h1, 8'h05, 8'h05, 8'h66, 3'h0, 8'h00, 3'h7},
    '{3'h3, 1'h0, 8'h10, 8'h01, 8'h77, 3'h6, 8'h0f, 3'h1},
    '{3'h4, 1'h1, 8'h00, 8'h05, 8'h03, 3'h7, 8'hfe, 3'h0},
    '{3'h4, 1'h0, 8'h00, 8'h88, 8'h88, 3'h0, 8'h00, 3'h7},
    '{3'h5, 1'h1, 8'h00, 8'h05, 8'h10, 3'h6, 8'h0a, 3'h1},
    '{3'h5, 1'h0, 8'h00, 8'h05, 8'h05, 3'h1, 8'h00, 3'h7},
    '{3'h5, 1'h1, 8'h00, 8'h05, 8'h05, 3'h6, 8'hff, 3'h0},
    '{3'h7, 1'h1, 8'h00, 8'h99, 8'h5a, 3'h5, 8'h5a, 3'h5},
    '{3'h0, 1'h0, 8'h00, 8'h42, 8'h24, 3'h2, 8'h42, 3'h2}};
  always #2 pclk = ~pclk;
  rsse_core rsse_core_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    results();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_STATUS, '0);
    check(rd, 32'h18);
    for (int i = 0; i < 13; i++) begin
      rw = rows[i];
      fa = OFF_FILE + 12'(4 * (i + 1));
      to_acc = rw.op == 3'h3 || !rw.d;
      apb(1'b1, OFF_ACC, {24'h0, rw.w});
      apb(1'b1, fa, {24'h0, rw.f});
      apb(1'b1, OFF_STATUS, {27'h0, 2'h3, rw.s});
      apb(1'b1, OFF_CMD, {8'h0, rw.k, 5'h0, 7'(i + 1), rw.d, rw.op});
      apb(1'b0, OFF_ACC, '0);
      check(rd, {24'h0, to_acc ? rw.r : rw.w});
      apb(1'b0, fa, '0);
      check(rd, {24'h0, to_acc ? rw.f : rw.r});
      apb(1'b0, OFF_STATUS, '0);
      check(rd, {27'h0, 2'h3, rw.fl});
    end
    // let counter and prescaler move off zero
    repeat (600) @(posedge pclk);
    apb(1'b1, OFF_STATUS, 32'hf);
    apb(1'b1, OFF_CMD, {29'h0, RSSE_SLEEP});
    apb(1'b0, OFF_WDOG, '0);
    // prescaler has counted two cycles since the sleep edge
    check(rd, 32'h200);
    apb(1'b0, OFF_STATUS, '0);
    check(rd, 32'h17);
    apb(1'b1, 12'h400, 32'h1);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h400, '0);
    check(rd, 32'h0);
    // reset again in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_STATUS, '0);
    check(rd, {27'h0, ST_RESET});
    apb(1'b0, OFF_ACC, '0);
    check(rd, 32'h0);
    results();
  end
endmodule
